// File: bench/card_host_model.sv
// host controller model issuing decoded commands and write requests
module card_host_model (
	input wire logic clk,
	output logic cmd_valid,
	output logic [5:0] cmd_index,
	output logic [31:0] cmd_arg,
	output logic write_req,
	output logic [9:0] write_bytes
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle lines at time zero
	initial begin
		cmd_valid = 1'h0;
		cmd_index = 6'h2a;
		cmd_arg = 32'h5a5a_5a5a;
		write_req = 1'h0;
		write_bytes = 10'h155;
	end

	// one command pulse, taken by the card at the edge of return
	task automatic send(logic [5:0] i, logic [31:0] a);
		@(posedge clk);
		cmd_valid <= 1'h1;
		cmd_index <= i;
		cmd_arg <= a;
		@(posedge clk);
		cmd_valid <= 1'h0;
		cmd_index <= ~i; // released lines carry junk
		cmd_arg <= ~a;
	endtask

	// address assignment, the reserved zero is never sent
	task automatic assign_addr(logic [15:0] a);
		if (a != 16'h0000) begin
			send(6'h03, {a, 16'h0000});
		end
	endtask

	// flag byte and checksum carried in the argument
	task automatic prog_flags(logic [7:0] f, logic [6:0] s);
		send(6'h1b, {16'h0000, f, s, 1'h1});
	endtask

	// one write block request of n bytes
	task automatic wr(logic [9:0] n);
		@(posedge clk);
		write_req <= 1'h1;
		write_bytes <= n;
		@(posedge clk);
		write_req <= 1'h0;
		write_bytes <= ~n;
	endtask
endmodule

// File: bench/test_card_info_registers.sv
// self-checking bench for the card information registers
module test_card_info_registers;
	timeunit 1ns;
	timeprecision 1ps;

	// identity and size fields handed to the card
	localparam logic [7:0] mk = 8'hc3; // arbitrary value
	localparam logic [15:0] app = 16'h1e2d; // arbitrary value
	localparam logic [47:0] pnm = 48'h4142_4344_4546;
	localparam logic [7:0] prv = 8'h21;
	localparam logic [31:0] psn = 32'h89ab_cdef;
	localparam logic [7:0] mdt = 8'h7c;
	localparam logic [6:0] isum = 7'h35;
	localparam logic [11:0] dsz = 12'h07a7;
	localparam logic [11:0] cur = 12'h05a3;
	localparam logic [4:0] egs = 5'h0b;
	localparam logic [127:0] id_exp = {mk, app, pnm, prv, psn, mdt, isum,
		1'h1};
	localparam logic [4:0] s_idle = card_regs_pkg::st_idle;
	localparam logic [4:0] s_ready = card_regs_pkg::st_ready;
	localparam logic [4:0] s_ident = card_regs_pkg::st_ident;
	localparam logic [4:0] s_stby = card_regs_pkg::st_standby;
	localparam logic [4:0] s_tran = card_regs_pkg::st_transfer;

	logic clk, resetn, cmd_valid, write_req;
	logic [5:0] cmd_index;
	logic [31:0] cmd_arg;
	logic [9:0] write_bytes;
	logic resp_valid_r, resp_long_r, selected_r, powered_r;
	logic write_accept_r, write_reject_r;
	logic [127:0] resp_data_r;
	card_regs_pkg::card_state_t state_r;
	int error_cnt, n_compared;

	card_info_registers #(.maker_code(mk), .app_code(app),
		.product_name(pnm), .product_rev(prv), .serial_no(psn),
		.make_date(mdt), .ident_crc(isum), .device_size(dsz),
		.supply_currents(cur), .size_multiplier(3'h3),
		.erase_group_size(egs)) dut (.clk(clk), .resetn(resetn),
		.cmd_valid(cmd_valid), .cmd_index(cmd_index), .cmd_arg(cmd_arg),
		.write_req(write_req), .write_bytes(write_bytes),
		.resp_valid_r(resp_valid_r), .resp_long_r(resp_long_r),
		.resp_data_r(resp_data_r), .state_r(state_r),
		.selected_r(selected_r), .powered_r(powered_r),
		.write_accept_r(write_accept_r), .write_reject_r(write_reject_r));

	card_host_model host (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_index(cmd_index), .cmd_arg(cmd_arg), .write_req(write_req),
		.write_bytes(write_bytes));

	// 250 MHz clock
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	// expected data record for a given flag byte and checksum
	function automatic logic [127:0] data_exp(logic [7:0] f, logic [6:0] s);
		data_exp = {2'h2, 4'h3, 2'h0, 8'h26, 8'h01, 8'h2a, 12'h0f5, 4'h9,
			6'h00, dsz, cur, 3'h3, egs, 5'h1f, 5'h03, 1'h1, 2'h0, 3'h4,
			4'h9, 1'h0, 5'h00, f, s, 1'h1};
	endfunction

	task automatic print_verdict();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(logic [127:0] seen, logic [127:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one command, then answer presence and state one edge later
	task automatic run(logic [5:0] i, logic [31:0] a, logic v,
		logic [4:0] st);
		host.send(i, a);
		#1;
		chk(resp_valid_r, v);
		chk(state_r, st);
	endtask

	// one write request, then the accept and refuse pulses
	task automatic wcheck(logic [9:0] n, logic [1:0] e);
		host.wr(n);
		#1;
		chk({write_accept_r, write_reject_r}, e);
	endtask

	task automatic do_reset();
		resetn <= 1'h0;
		repeat (20) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		#1;
		chk({state_r, powered_r, selected_r}, {s_idle, 2'h0});
	endtask

	// bounded wait for the end of the power-up busy period
	task automatic wait_power();
		int n;
		n = 0;
		while (powered_r !== 1'h1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 3000) begin
			error_cnt++;
			print_verdict();
		end
	endtask

	task automatic t_power();
		run(6'h01, 32'h0000_0000, 1'h1, s_idle);
		chk(resp_data_r[31:0], 32'h00ff_8000);
		run(6'h02, 32'h0000_0000, 1'h0, s_idle);
	endtask

	task automatic bring_up(logic [15:0] a);
		wait_power();
		run(6'h01, 32'h0000_0000, 1'h1, s_ready);
		chk(resp_data_r[31:0], 32'h80ff_8000);
		run(6'h02, 32'h0000_0000, 1'h1, s_ident);
		chk(resp_long_r, 1'h1);
		chk(resp_data_r, id_exp);
		run(6'h03, 32'h0000_0000, 1'h0, s_ident);
		host.assign_addr(a);
		#1;
		chk({resp_valid_r, state_r}, {1'h1, s_stby});
		chk(resp_data_r[31:0], {a, 16'h0004});
	endtask

	task automatic t_read();
		run(6'h09, 32'h0001_0000, 1'h0, s_stby);
		run(6'h0a, 32'h1234_0000, 1'h1, s_stby);
		chk(resp_data_r, id_exp);
		run(6'h09, 32'h1234_0000, 1'h1, s_stby);
		chk(resp_data_r, data_exp(8'h40, 7'h00));
		run(6'h1b, 32'h0000_ff01, 1'h0, s_stby);
		run(6'h01, 32'h0000_0000, 1'h0, s_stby);
		run(6'h05, 32'h1234_0000, 1'h0, s_stby);
	endtask

	task automatic t_write();
		wcheck(10'h200, 2'h1);
		run(6'h07, 32'h1234_0000, 1'h1, s_tran);
		chk({selected_r, resp_data_r[31:0]}, {1'h1, 32'h1234_0008});
		wcheck(10'h200, 2'h2);
		wcheck(10'h1ff, 2'h1);
		wcheck(10'h3ff, 2'h1);
	endtask

	task automatic t_prog();
		host.prog_flags(8'hb0, 7'h55);
		#1;
		chk(resp_valid_r, 1'h1);
		chk(resp_data_r[31:0], 32'h1234_0010);
		host.prog_flags(8'h00, 7'h55);
		#1;
		chk(resp_valid_r, 1'h1);
		run(6'h07, 32'h0000_0000, 1'h0, s_stby);
		chk(selected_r, 1'h0);
		run(6'h09, 32'h1234_0000, 1'h1, s_stby);
		chk(resp_data_r, data_exp(8'h20, 7'h55));
		run(6'h07, 32'h1234_0000, 1'h1, s_tran);
		run(6'h07, 32'h5555_0000, 1'h0, s_stby);
		run(6'h00, 32'h0000_0000, 1'h0, s_idle);
	endtask

	task automatic t_reset();
		do_reset();
		bring_up(16'h00aa);
		run(6'h09, 32'h00aa_0000, 1'h1, s_stby);
		chk(resp_data_r, data_exp(8'h40, 7'h00));
	endtask

	// main sequence
	initial begin
		resetn = 1'h0;
		error_cnt = 0;
		n_compared = 0;
		do_reset();
		t_power();
		bring_up(16'h1234);
		t_read();
		t_write();
		t_prog();
		t_reset();
		print_verdict();
	end
endmodule

// File: design/card_info_registers.sv
// card information registers answering decoded host commands
// Overview of operation
// - busy flag on top, bits 30..24 zero
// - 128-bit identity record, fixed, sent during identification
// - identity record in eight slices, last bit one
// - host assigns sixteen-bit address, card stores it
// - address register holds 0x0001 until assigned
// - address zero deselects to standby, never assigned
// - set-address command loads the address register
// - power-up reset restores the default address
// - addressed commands answered only on address match
// - layout, version, access time, rate fields fixed
// - erase group multiplier fixed at 0x1F
// - protect group size 0x3, enable bit set
// - write block length code 0x9, 512 bytes
// - partial writes disallowed, only full blocks accepted
// - condition and identity read-only, address host-written, read back in select and program answers
module card_info_registers #(
	parameter logic [7:0] maker_code = 8'ha5, // arbitrary value
	parameter logic [15:0] app_code = 16'h5a5a, // arbitrary value
	parameter logic [47:0] product_name = 48'h0000_0000_0000,
	parameter logic [7:0] product_rev = 8'h10,
	parameter logic [31:0] serial_no = 32'h0000_0001,
	parameter logic [7:0] make_date = 8'h00,
	parameter logic [6:0] ident_crc = 7'h00,
	parameter logic [11:0] device_size = 12'h07a7,
	parameter logic [11:0] supply_currents = 12'h000,
	parameter logic [2:0] size_multiplier = 3'h3,
	parameter logic [4:0] erase_group_size = 5'h00
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic [5:0] cmd_index,
	input wire logic [31:0] cmd_arg,
	input wire logic write_req,
	input wire logic [9:0] write_bytes,
	output logic resp_valid_r,
	output logic resp_long_r,
	output logic [127:0] resp_data_r,
	output card_regs_pkg::card_state_t state_r,
	output logic selected_r,
	output logic powered_r,
	output logic write_accept_r,
	output logic write_reject_r
);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	card_regs_pkg::card_state_t state_nxt;
	logic [11:0] pwr_cnt_r;
	logic [15:0] card_addr;
	logic addr_hit;
	logic addr_load;
	logic flag_prog;
	logic [7:0] flags_val;
	logic [6:0] crc_val;
	logic [31:0] cond_word;
	logic [127:0] ident_rec;
	logic [127:0] spec_rec;
	logic resp_nxt;
	logic long_nxt;
	logic [127:0] data_nxt;
	logic loaded_r;
	logic in_idle;
	logic in_ready;
	logic in_ident;
	logic in_standby;
	logic in_transfer;

	assign in_idle = (state_r == card_regs_pkg::st_idle);
	assign in_ready = (state_r == card_regs_pkg::st_ready);
	assign in_ident = (state_r == card_regs_pkg::st_ident);
	assign in_standby = (state_r == card_regs_pkg::st_standby);
	assign in_transfer = (state_r == card_regs_pkg::st_transfer);

	// relative address storage, written only by set-address
	rel_addr_reg u_addr (
		.clk(clk),
		.resetn(resetn),
		.load(addr_load),
		.load_val(cmd_arg[31:16]),
		.probe(cmd_arg[31:16]),
		.addr_r(card_addr),
		.match(addr_hit)
	);

	// programmable part of the card-specific-data record
	rec_flag_reg u_flags (
		.clk(clk),
		.resetn(resetn),
		.prog(flag_prog),
		.prog_flags(cmd_arg[15:8]),
		.prog_crc(cmd_arg[7:1]),
		.flags_r(flags_val),
		.crc_r(crc_val)
	);

	// power-up busy counter; flag rises once the period has run
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwr_cnt_r <= 12'h000;
			powered_r <= 1'b0;
		end else if (!powered_r) begin
			pwr_cnt_r <= pwr_cnt_r + 12'h001;
			powered_r <= (pwr_cnt_r == card_regs_pkg::powerup_last);
		end
	end

	// operating-condition word, read-only image
	assign cond_word = {powered_r, card_regs_pkg::cond_reserved,
		card_regs_pkg::cond_window[23:0]};

	// identity record, fixed at build time
	assign ident_rec = {maker_code, app_code, product_name, product_rev,
		serial_no, make_date, ident_crc,
		card_regs_pkg::ident_tail};

	// card-specific-data record: fixed fields plus flag byte and checksum
	assign spec_rec = {card_regs_pkg::record_layout_code,
		card_regs_pkg::spec_version_code, 2'h0,
		card_regs_pkg::async_access_time,
		card_regs_pkg::clocked_access_time,
		card_regs_pkg::transfer_rate,
		card_regs_pkg::command_classes,
		card_regs_pkg::read_block_length, 4'h0, 2'h0,
		device_size, supply_currents, size_multiplier,
		erase_group_size, card_regs_pkg::erase_group_multiplier,
		card_regs_pkg::protect_group_size,
		card_regs_pkg::protect_group_enable, 2'h0,
		card_regs_pkg::write_speed_factor,
		card_regs_pkg::write_block_length,
		card_regs_pkg::partial_write_allowed, 5'h00,
		flags_val, crc_val, 1'h1};

	// command decode: state moves, loads and answers
	always_comb begin
		state_nxt = state_r;
		resp_nxt = 1'b0;
		long_nxt = 1'b0;
		data_nxt = resp_data_r;
		addr_load = 1'b0;
		flag_prog = 1'b0;
		if (cmd_valid) begin
			case (cmd_index)
				card_regs_pkg::cmd_go_idle: begin
					state_nxt = card_regs_pkg::st_idle;
				end
				card_regs_pkg::cmd_send_op: begin
					if (in_idle || in_ready) begin
						resp_nxt = 1'b1;
						data_nxt = {96'h0, cond_word};
						if (powered_r) begin
							state_nxt = card_regs_pkg::st_ready;
						end
					end
				end
				card_regs_pkg::cmd_all_ident: begin
					if (in_ready) begin
						resp_nxt = 1'b1;
						long_nxt = 1'b1;
						data_nxt = ident_rec;
						state_nxt = card_regs_pkg::st_ident;
					end
				end
				card_regs_pkg::cmd_set_addr: begin
					// zero is never taken as a card address
					if ((in_ident || in_standby) &&
						cmd_arg[31:16] != card_regs_pkg::addr_broadcast) begin
						addr_load = 1'b1;
						resp_nxt = 1'b1;
						data_nxt = {96'h0, cmd_arg[31:16], 11'h0, state_r};
						state_nxt = card_regs_pkg::st_standby;
					end
				end
				card_regs_pkg::card_select_command: begin
					if (cmd_arg[31:16] == card_regs_pkg::addr_broadcast) begin
						if (in_transfer) begin
							state_nxt = card_regs_pkg::st_standby;
						end
					end else if (addr_hit && in_standby) begin
						resp_nxt = 1'b1;
						data_nxt = {96'h0, card_addr, 11'h0, state_r};
						state_nxt = card_regs_pkg::st_transfer;
					end else if (!addr_hit && in_transfer) begin
						state_nxt = card_regs_pkg::st_standby;
					end
				end
				card_regs_pkg::cmd_send_rec: begin
					if (addr_hit && in_standby) begin
						resp_nxt = 1'b1;
						long_nxt = 1'b1;
						data_nxt = spec_rec;
					end
				end
				card_regs_pkg::cmd_send_ident: begin
					if (addr_hit && in_standby) begin
						resp_nxt = 1'b1;
						long_nxt = 1'b1;
						data_nxt = ident_rec;
					end
				end
				card_regs_pkg::cmd_prog_rec: begin
					if (in_transfer) begin
						flag_prog = 1'b1;
						resp_nxt = 1'b1;
						data_nxt = {96'h0, card_addr, 11'h0, state_r};
					end
				end
				default: begin
					state_nxt = state_r;
				end
			endcase
		end
	end

	// card state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= card_regs_pkg::st_idle;
			selected_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			selected_r <= (state_nxt == card_regs_pkg::st_transfer);
		end
	end

	// response register, one-cycle valid after the command
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			resp_valid_r <= 1'b0;
			resp_long_r <= 1'b0;
			resp_data_r <= 128'h0;
		end else begin
			resp_valid_r <= resp_nxt;
			resp_long_r <= long_nxt;
			resp_data_r <= data_nxt;
		end
	end

	// write block check: only full 512-byte blocks when selected
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			write_accept_r <= 1'b0;
			write_reject_r <= 1'b0;
		end else begin
			write_accept_r <= write_req && in_transfer &&
				write_bytes == card_regs_pkg::write_block_bytes;
			write_reject_r <= write_req && !(in_transfer &&
				write_bytes == card_regs_pkg::write_block_bytes);
		end
	end

	// helper: address register has been loaded since reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			loaded_r <= 1'b0;
		end else if (addr_load) begin
			loaded_r <= 1'b1;
		end
	end

	sequence op_cmd_s;
		cmd_valid && cmd_index == card_regs_pkg::cmd_send_op &&
			(in_idle || in_ready);
	endsequence

	sequence set_addr_s;
		cmd_valid && cmd_index == card_regs_pkg::cmd_set_addr &&
			(in_ident || in_standby) &&
			cmd_arg[31:16] != card_regs_pkg::addr_broadcast;
	endsequence

	sequence rec_read_s;
		cmd_valid && cmd_index == card_regs_pkg::cmd_send_rec &&
			in_standby && addr_hit;
	endsequence

	sequence prog_s;
		cmd_valid && cmd_index == card_regs_pkg::cmd_prog_rec && in_transfer;
	endsequence

	cond_reserved_a: assert property (op_cmd_s |=> resp_valid_r &&
		resp_data_r[31:0] == {$past(powered_r), 31'h00ff_8000})
		else $error("condition word busy or reserved bits wrong");

	cond_window_a: assert property (op_cmd_s |=>
		resp_data_r[23:15] == 9'h1ff && resp_data_r[14:8] == 7'h00)
		else $error("voltage window bits wrong");

	ident_slices_a: assert property ((cmd_valid && in_ready &&
		cmd_index == card_regs_pkg::cmd_all_ident) |=> resp_long_r &&
		resp_data_r[0] && resp_data_r[127:120] == maker_code &&
		state_r == card_regs_pkg::st_ident)
		else $error("identity record answer wrong");

	addr_default_a: assert property (!loaded_r |->
		card_addr == card_regs_pkg::addr_default)
		else $error("address register left default without load");

	// back-to-back select may follow, so selection is judged at once
	addr_latch_a: assert property (set_addr_s |=>
		card_addr == $past(cmd_arg[31:16]) &&
		state_r == card_regs_pkg::st_standby && !selected_r)
		else $error("set-address did not latch");

	deselect_all_a: assert property ((cmd_valid && in_transfer &&
		cmd_index == card_regs_pkg::card_select_command &&
		cmd_arg[31:16] == card_regs_pkg::addr_broadcast) |=>
		state_r == card_regs_pkg::st_standby && !resp_valid_r &&
		!selected_r)
		else $error("broadcast deselect failed");

	addr_gate_a: assert property ((cmd_valid && !addr_hit &&
		(cmd_index == card_regs_pkg::cmd_send_rec ||
		cmd_index == card_regs_pkg::cmd_send_ident)) |=> !resp_valid_r)
		else $error("answered command for another address");

	rec_fixed_a: assert property (rec_read_s |=>
		resp_long_r &&
		resp_data_r[card_regs_pkg::layout_lo +: 2] == 2'h2 &&
		resp_data_r[card_regs_pkg::spec_lo +: 4] == 4'h3 &&
		resp_data_r[card_regs_pkg::access_lo +: 8] == 8'h26 &&
		resp_data_r[card_regs_pkg::rate_lo +: 8] == 8'h2a &&
		resp_data_r[card_regs_pkg::erase_mult_lo +: 5] == 5'h1f &&
		resp_data_r[card_regs_pkg::protect_size_lo +: 5] == 5'h03 &&
		resp_data_r[card_regs_pkg::protect_en_pos] &&
		resp_data_r[card_regs_pkg::write_len_lo +: 4] == 4'h9 &&
		!resp_data_r[card_regs_pkg::partial_pos])
		else $error("fixed record field wrong");

	flag_prog_a: assert property (prog_s |=>
		spec_rec[card_regs_pkg::flags_lo +: 8] ==
		($past(cmd_arg[15:8]) | {2'h0, $past(flags_val[5]), 5'h00}))
		else $error("flag byte not programmed");

	full_block_a: assert property ((write_req &&
		write_bytes != card_regs_pkg::write_block_bytes) |=>
		write_reject_r && !write_accept_r)
		else $error("partial write block accepted");

endmodule

// File: design/card_regs_pkg.sv
// constants, command codes and card states for the card information registers
package card_regs_pkg;

	// power-up busy period before the card reports ready
	localparam int unsigned clk_mhz = 250;
	localparam int unsigned powerup_time_us = 10;
	localparam int unsigned powerup_cycles = powerup_time_us * clk_mhz;
	localparam logic [11:0] powerup_last = 12'(powerup_cycles - 1);

	// operating-condition word: window 2.7 V..3.6 V in bits 23..15
	localparam int unsigned cond_busy_pos = 31;
	localparam logic [31:0] cond_window = 32'h00ff_8000;
	localparam logic [6:0] cond_reserved = 7'h00;

	// relative address values
	localparam logic [15:0] addr_default = 16'h0001;
	localparam logic [15:0] addr_broadcast = 16'h0000;

	// command codes seen on the decoded command port
	localparam logic [5:0] cmd_go_idle = 6'h00;
	localparam logic [5:0] cmd_send_op = 6'h01;
	localparam logic [5:0] cmd_all_ident = 6'h02;
	localparam logic [5:0] cmd_set_addr = 6'h03;
	localparam logic [5:0] card_select_command = 6'h07;
	localparam logic [5:0] cmd_send_rec = 6'h09;
	localparam logic [5:0] cmd_send_ident = 6'h0a;
	localparam logic [5:0] cmd_prog_rec = 6'h1b;

	// identity record tail bit
	localparam logic ident_tail = 1'h1;

	// card-specific-data fixed fields
	localparam logic [1:0] record_layout_code = 2'h2;
	localparam logic [3:0] spec_version_code = 4'h3;
	localparam logic [7:0] async_access_time = 8'h26;
	localparam logic [7:0] clocked_access_time = 8'h01;
	localparam logic [7:0] transfer_rate = 8'h2a;
	localparam logic [11:0] command_classes = 12'h0f5;
	localparam logic [3:0] read_block_length = 4'h9;
	localparam logic [4:0] erase_group_multiplier = 5'h1f;
	localparam logic [4:0] protect_group_size = 5'h03;
	localparam logic protect_group_enable = 1'h1;
	localparam logic [2:0] write_speed_factor = 3'h4;
	localparam logic [3:0] write_block_length = 4'h9;
	localparam logic partial_write_allowed = 1'h0;
	localparam logic [9:0] write_block_bytes = 10'h200;

	// field positions inside the card-specific-data record
	localparam int unsigned layout_lo = 126;
	localparam int unsigned spec_lo = 122;
	localparam int unsigned access_lo = 112;
	localparam int unsigned rate_lo = 96;
	localparam int unsigned erase_mult_lo = 37;
	localparam int unsigned protect_size_lo = 32;
	localparam int unsigned protect_en_pos = 31;
	localparam int unsigned write_len_lo = 22;
	localparam int unsigned partial_pos = 21;
	localparam int unsigned flags_lo = 8;

	// host-programmable flag byte: format grp, copy, perm, temp, format, ecc
	localparam logic [7:0] flags_reset = 8'h40;
	localparam int unsigned permanent_protect_flag = 5;
	localparam logic [6:0] crc_reset = 7'h00;

	// card states, one-hot
	typedef enum logic [4:0] {
		st_idle = 5'h01,
		st_ready = 5'h02,
		st_ident = 5'h04,
		st_standby = 5'h08,
		st_transfer = 5'h10
	} card_state_t;

endpackage

// File: design/csd_flag_reg.sv
// host-programmable flag byte and checksum of the card-specific-data record
module rec_flag_reg (
	input wire logic clk,
	input wire logic resetn,
	input wire logic prog,
	input wire logic [7:0] prog_flags,
	input wire logic [6:0] prog_crc,
	output logic [7:0] flags_r,
	output logic [6:0] crc_r
);

	logic [7:0] flags_nxt;

	// permanent protection can be set but never cleared by a program command, only by reset
	always_comb begin
		flags_nxt = prog_flags;
		flags_nxt[card_regs_pkg::permanent_protect_flag] =
			prog_flags[card_regs_pkg::permanent_protect_flag] |
			flags_r[card_regs_pkg::permanent_protect_flag];
	end

	// flag byte and checksum update on a program command
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_r <= card_regs_pkg::flags_reset;
			crc_r <= card_regs_pkg::crc_reset;
		end else if (prog) begin
			flags_r <= flags_nxt;
			crc_r <= prog_crc;
		end
	end

endmodule

// File: design/rel_addr_reg.sv
// relative card address register with power-up default and compare
module rel_addr_reg (
	input wire logic clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [15:0] load_val,
	input wire logic [15:0] probe,
	output logic [15:0] addr_r,
	output logic match
);

	// default restored by power-up reset, host value latched on load
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_r <= card_regs_pkg::addr_default;
		end else if (load) begin
			addr_r <= load_val;
		end
	end

	// address compare for addressed commands
	assign match = (probe == addr_r);

endmodule
